// file: hdl/ebc_pkg.sv
`default_nettype none
package ebc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets on the APB
   localparam logic [7:0] EBC_OFS_CTRL = 8'h00;
   localparam logic [7:0] EBC_OFS_ADDR = 8'h04;
   localparam logic [7:0] EBC_OFS_WDATA = 8'h08;
   localparam logic [7:0] EBC_OFS_CMD = 8'h0c;
   localparam logic [7:0] EBC_OFS_RDATA = 8'h10;
   localparam logic [7:0] EBC_OFS_STATUS = 8'h14;

   // Control register fields
   localparam int EBC_CTRL_SINGLE_BIT = 0;
   localparam int EBC_CTRL_MUX_BIT = 1;
   localparam int EBC_CTRL_CYC_LSB = 4;
   localparam logic [3:0] EBC_CYC_RST = 4'h3;

   // Command register fields
   localparam int EBC_CMD_GO_BIT = 0;
   localparam int EBC_CMD_WR_BIT = 1;
   localparam int EBC_CMD_WORD_BIT = 2;

   // Status register fields
   localparam int EBC_ST_BUSY_BIT = 0;
   localparam int EBC_ST_HOLD_BIT = 1;
   localparam int EBC_ST_MICRO_BIT = 2;
   localparam int EBC_ST_BUS8_BIT = 3;
   localparam int EBC_ST_SINGLE_BIT = 4;
   localparam int EBC_ST_REFUSED_BIT = 5;
   localparam int EBC_ST_STRAP_BIT = 6;

   // Bus geometry
   localparam int EBC_ADDR_W = 20;
   localparam int EBC_DATA_W = 16;
   localparam int EBC_CS_N = 4;
   localparam int EBC_CS_LSB = 18;

   // Edges after reset release before straps are caught
   localparam logic [1:0] EBC_STRAP_WAIT = 2'd2;

   ////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [2:0] {
      EBC_IDLE = 3'b000,
      EBC_LATCH = 3'b001,
      EBC_STROBE = 3'b010,
      EBC_RECOVER = 3'b011,
      EBC_HOLD = 3'b100
   } ebc_fsm_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } ebc_apb_req_t;

   typedef struct packed {
      logic [19:0] addr;
      logic addr_oe;
      logic [15:0] dout;
      logic [1:0] data_oe;
      logic [3:0] cs_n;
      logic ctl_oe;
      logic ale;
      logic wrl_n;
      logic wrh_n;
      logic wr_n;
      logic bhe_n;
      logic rd_n;
      logic grant_n;
   } ebc_pins_t;

   localparam ebc_pins_t EBC_PINS_RST = '{
      addr: 20'h00000, addr_oe: 1'b0, dout: 16'h0000, data_oe: 2'b00,
      cs_n: 4'hf, ctl_oe: 1'b0, ale: 1'b0, wrl_n: 1'b1, wrh_n: 1'b1,
      wr_n: 1'b1, bhe_n: 1'b1, rd_n: 1'b1, grant_n: 1'b1};

endpackage : ebc_pkg
`default_nettype wire

// file: hdl/ebc_ctrl.sv
// The register offsets and the APB interface to the registers are this design's own decisions.
`default_nettype none
module ebc_ctrl
   import ebc_pkg::*;
#(
   parameter logic [3:0] STROBE_CYC_RST = EBC_CYC_RST
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire ebc_apb_req_t apb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic boot_mode_pin_i,
   input wire logic bus_width_select_i,
   input wire logic bus_request_n_i,
   input wire logic wait_request_n_i,
   input wire logic [15:0] ext_data_i,
   output logic [15:0] ext_data_o,
   output logic [15:0] ext_data_oe_o,
   output logic [19:0] ext_addr_o,
   output logic ext_addr_oe_o,
   output logic [3:0] chip_select_n_o,
   output logic ctl_oe_o,
   output logic addr_latch_pulse_o,
   output logic low_byte_store_n_o,
   output logic high_byte_store_n_o,
   output logic store_strobe_n_o,
   output logic upper_byte_enable_n_o,
   output logic read_strobe_n_o,
   output logic bus_grant_n_o
);

   ////////////////////////////////////////////////////////////////////////
   // Parameter check
   if (STROBE_CYC_RST == 4'h0) begin : g_bad_cyc
      $error("STROBE_CYC_RST must be at least one");
   end

   ////////////////////////////////////////////////////////////////////////
   // Whole module state
   typedef struct packed {
      ebc_fsm_t fsm;
      ebc_pins_t pins;
      logic [1:0] boot_s;
      logic [1:0] width_s;
      logic [1:0] hold_s;
      logic [1:0] wait_s;
      logic [15:0] din_s1;
      logic [15:0] din_s2;
      logic [1:0] strap_cnt;
      logic strap_done;
      logic micro_mode;
      logic bus8;
      logic single_sel;
      logic mux_en;
      logic [3:0] cyc;
      logic [19:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic [19:0] acc_addr;
      logic acc_wr;
      logic acc_word;
      logic busy;
      logic refused;
      logic [3:0] cnt;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ebc_state_t;

   ebc_state_t state_r;
   ebc_state_t state_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      logic eff_single;
      logic odd;
      logic word16;
      logic sep16;
      logic apb_acc;
      logic apb_done;
      logic [31:0] rd_val;
      logic [7:0] ofs;
      logic active;
      eff_single = 1'b0;
      odd = 1'b0;
      word16 = 1'b0;
      sep16 = 1'b0;
      apb_acc = 1'b0;
      apb_done = 1'b0;
      rd_val = 32'h00000000;
      ofs = 8'h00;
      active = 1'b0;
      state_nxt = state_r;

      // Pin synchronisers, only the second stage is read
      state_nxt.boot_s = {state_r.boot_s[0], boot_mode_pin_i};
      state_nxt.width_s = {state_r.width_s[0], bus_width_select_i};
      state_nxt.hold_s = {state_r.hold_s[0], bus_request_n_i};
      state_nxt.wait_s = {state_r.wait_s[0], wait_request_n_i};
      state_nxt.din_s1 = ext_data_i;
      state_nxt.din_s2 = state_r.din_s1;

      if (!state_r.strap_done) begin
         if (state_r.strap_cnt == EBC_STRAP_WAIT) begin
            state_nxt.strap_done = 1'b1;
            state_nxt.micro_mode = state_r.boot_s[1];
            state_nxt.bus8 = state_r.width_s[1];
         end else begin
            state_nxt.strap_cnt = state_r.strap_cnt + 2'd1;
         end
      end

      eff_single = state_r.single_sel | state_r.bus8;
      odd = state_r.acc_addr[0];
      sep16 = ~state_r.bus8 & ~state_r.mux_en;
      word16 = state_r.acc_word & sep16;

      // APB read decode, answered one cycle into the access phase
      ofs = apb_i.paddr;
      apb_acc = apb_i.psel & apb_i.penable & ~state_r.pready;
      apb_done = apb_i.psel & apb_i.penable & state_r.pready;
      state_nxt.pready = apb_acc;
      state_nxt.pslverr = 1'b0;
      if (apb_acc) begin
         case (ofs)
            EBC_OFS_CTRL: begin
               rd_val[EBC_CTRL_SINGLE_BIT] = state_r.single_sel;
               rd_val[EBC_CTRL_MUX_BIT] = state_r.mux_en;
               rd_val[EBC_CTRL_CYC_LSB +: 4] = state_r.cyc;
            end
            EBC_OFS_ADDR: rd_val[19:0] = state_r.addr;
            EBC_OFS_WDATA: rd_val[15:0] = state_r.wdata;
            EBC_OFS_CMD: rd_val = 32'h00000000;
            EBC_OFS_RDATA: rd_val[15:0] = state_r.rdata;
            EBC_OFS_STATUS: begin
               rd_val[EBC_ST_BUSY_BIT] = state_r.busy;
               rd_val[EBC_ST_HOLD_BIT] = (state_r.fsm == EBC_HOLD);
               rd_val[EBC_ST_MICRO_BIT] = state_r.micro_mode;
               rd_val[EBC_ST_BUS8_BIT] = state_r.bus8;
               rd_val[EBC_ST_SINGLE_BIT] = eff_single;
               rd_val[EBC_ST_REFUSED_BIT] = state_r.refused;
               rd_val[EBC_ST_STRAP_BIT] = state_r.strap_done;
            end
            default: state_nxt.pslverr = 1'b1;
         endcase
         state_nxt.prdata = apb_i.pwrite ? 32'h00000000 : rd_val;
      end

      // APB writes take effect on the completing edge
      if (apb_done && apb_i.pwrite) begin
         case (ofs)
            EBC_OFS_CTRL: begin
               state_nxt.single_sel = apb_i.pwdata[EBC_CTRL_SINGLE_BIT];
               state_nxt.mux_en = apb_i.pwdata[EBC_CTRL_MUX_BIT];
               if (apb_i.pwdata[EBC_CTRL_CYC_LSB +: 4] != 4'h0) begin
                  state_nxt.cyc = apb_i.pwdata[EBC_CTRL_CYC_LSB +: 4];
               end
            end
            EBC_OFS_ADDR: state_nxt.addr = apb_i.pwdata[19:0];
            EBC_OFS_WDATA: state_nxt.wdata = apb_i.pwdata[15:0];
            EBC_OFS_STATUS: begin
               if (apb_i.pwdata[EBC_ST_REFUSED_BIT]) begin
                  state_nxt.refused = 1'b0;
               end
            end
            EBC_OFS_CMD: begin
               if (apb_i.pwdata[EBC_CMD_GO_BIT]) begin
                  if (state_r.busy || !state_r.micro_mode ||
                      !state_r.strap_done) begin
                     state_nxt.refused = 1'b1;
                  end else begin
                     state_nxt.busy = 1'b1;
                     state_nxt.acc_addr = state_r.addr;
                     state_nxt.acc_wr = apb_i.pwdata[EBC_CMD_WR_BIT];
                     state_nxt.acc_word = apb_i.pwdata[EBC_CMD_WORD_BIT];
                  end
               end
            end
            default: state_nxt.refused = state_r.refused;
         endcase
      end

      // Access sequencer
      case (state_r.fsm)
         EBC_IDLE: begin
            if (state_r.strap_done && !state_r.hold_s[1]) begin
               state_nxt.fsm = EBC_HOLD;
            end else if (state_r.busy) begin
               state_nxt.fsm = EBC_LATCH;
            end
         end
         EBC_LATCH: begin
            state_nxt.fsm = EBC_STROBE;
            state_nxt.cnt = state_r.cyc - 4'd1;
         end
         EBC_STROBE: begin
            if (state_r.cnt != 4'h0) begin
               state_nxt.cnt = state_r.cnt - 4'd1;
            end else if (state_r.wait_s[1]) begin
               state_nxt.fsm = EBC_RECOVER;
               if (!state_r.acc_wr) begin
                  if (word16) begin
                     state_nxt.rdata = state_r.din_s2;
                  end else if (sep16 && odd) begin
                     state_nxt.rdata = {8'h00, state_r.din_s2[15:8]};
                  end else begin
                     state_nxt.rdata = {8'h00, state_r.din_s2[7:0]};
                  end
               end
            end
         end
         EBC_RECOVER: begin
            state_nxt.fsm = EBC_IDLE;
            state_nxt.busy = 1'b0;
         end
         EBC_HOLD: begin
            if (state_r.hold_s[1]) begin
               state_nxt.fsm = EBC_IDLE;
            end
         end
         default: state_nxt.fsm = EBC_IDLE;
      endcase

      // Pin values registered from the next state
      state_nxt.pins = EBC_PINS_RST;
      state_nxt.pins.addr = state_nxt.acc_addr;
      active = (state_nxt.fsm == EBC_LATCH) ||
               (state_nxt.fsm == EBC_STROBE) ||
               (state_nxt.fsm == EBC_RECOVER);
      if (state_nxt.strap_done && state_nxt.micro_mode &&
          state_nxt.fsm != EBC_HOLD) begin
         state_nxt.pins.addr_oe = 1'b1;
         state_nxt.pins.ctl_oe = 1'b1;
      end
      state_nxt.pins.grant_n = (state_nxt.fsm != EBC_HOLD);
      if (active) begin
         state_nxt.pins.cs_n[state_nxt.acc_addr[EBC_CS_LSB +: 2]] = 1'b0;
         if (eff_single) begin
            state_nxt.pins.bhe_n = ~(odd | word16);
         end
      end
      if (state_nxt.fsm == EBC_LATCH) begin
         state_nxt.pins.ale = 1'b1;
         if (state_r.mux_en) begin
            state_nxt.pins.dout[7:0] = state_r.bus8 ?
               state_nxt.acc_addr[7:0] : state_nxt.acc_addr[8:1];
            state_nxt.pins.data_oe[0] = 1'b1;
         end
      end
      if ((state_nxt.fsm == EBC_STROBE || state_nxt.fsm == EBC_RECOVER) &&
          state_r.acc_wr) begin
         state_nxt.pins.dout = word16 ? state_r.wdata :
            {state_r.wdata[7:0], state_r.wdata[7:0]};
         state_nxt.pins.data_oe[0] = ~sep16 | ~odd | word16;
         state_nxt.pins.data_oe[1] = sep16 & (odd | word16);
      end
      if (state_nxt.fsm == EBC_STROBE) begin
         state_nxt.pins.rd_n = state_r.acc_wr;
         if (eff_single) begin
            state_nxt.pins.wr_n = ~state_r.acc_wr;
         end else begin
            state_nxt.pins.wrl_n = ~(state_r.acc_wr & (~odd | word16));
            state_nxt.pins.wrh_n = ~(state_r.acc_wr & (odd | word16));
         end
      end

      if (!rstn_i) begin
         state_nxt = '0;
         state_nxt.fsm = EBC_IDLE;
         state_nxt.pins = EBC_PINS_RST;
         state_nxt.cyc = STROBE_CYC_RST;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge ref_clk_i) begin
      state_r <= state_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign prdata_o = state_r.prdata;
   assign pready_o = state_r.pready;
   assign pslverr_o = state_r.pslverr;
   assign ext_data_o = state_r.pins.dout;
   assign ext_data_oe_o = {{8{state_r.pins.data_oe[1]}},
                           {8{state_r.pins.data_oe[0]}}};
   assign ext_addr_o = state_r.pins.addr;
   assign ext_addr_oe_o = state_r.pins.addr_oe;
   assign chip_select_n_o = state_r.pins.cs_n;
   assign ctl_oe_o = state_r.pins.ctl_oe;
   assign addr_latch_pulse_o = state_r.pins.ale;
   assign low_byte_store_n_o = state_r.pins.wrl_n;
   assign high_byte_store_n_o = state_r.pins.wrh_n;
   assign store_strobe_n_o = state_r.pins.wr_n;
   assign upper_byte_enable_n_o = state_r.pins.bhe_n;
   assign read_strobe_n_o = state_r.pins.rd_n;
   assign bus_grant_n_o = state_r.pins.grant_n;

endmodule : ebc_ctrl
`default_nettype wire

// file: verif/ebc_ctrl_sva.sv
`default_nettype none
module ebc_ctrl_sva
   import ebc_pkg::*;
#(
   parameter logic [3:0] STROBE_CYC_RST = EBC_CYC_RST
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic bus_width_select_i,
   input wire logic bus_request_n_i,
   input wire logic wait_request_n_i,
   input wire logic [15:0] ext_data_o,
   input wire logic [15:0] ext_data_oe_o,
   input wire logic [19:0] ext_addr_o,
   input wire logic ext_addr_oe_o,
   input wire logic [3:0] chip_select_n_o,
   input wire logic ctl_oe_o,
   input wire logic addr_latch_pulse_o,
   input wire logic low_byte_store_n_o,
   input wire logic high_byte_store_n_o,
   input wire logic store_strobe_n_o,
   input wire logic read_strobe_n_o,
   input wire logic bus_grant_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Any strobe of either scheme low
   wire logic stb = !(read_strobe_n_o & store_strobe_n_o &
      low_byte_store_n_o & high_byte_store_n_o);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rstn_i);
   AST_HOLD_OFF: assert property (
      !bus_grant_n_o |-> !ext_addr_oe_o && !ctl_oe_o && ext_data_oe_o == 16'h0
   ) else $error("bus driven in hold");
   AST_HOLD_KEEP: assert property (
      !bus_request_n_i [*3] ##0 !bus_grant_n_o |=> !bus_grant_n_o
   ) else $error("hold left early");
   AST_GRANT_REL: assert property (
      bus_request_n_i [*4] |-> bus_grant_n_o) else $error("grant stuck");
   AST_ADDR_STABLE: assert property (
      stb |-> $stable(ext_addr_o) && $stable(chip_select_n_o)
   ) else $error("address moved in strobe");
   AST_CS_DECODE: assert property (
      addr_latch_pulse_o |-> chip_select_n_o == ~(4'h1 << ext_addr_o[19:18])
   ) else $error("wrong select");
   AST_MUX_ADDR: assert property (
      addr_latch_pulse_o && ext_data_oe_o[0] |-> ext_data_o[7:0] ==
      (bus_width_select_i ? ext_addr_o[7:0] : ext_addr_o[8:1])
   ) else $error("wrong shared address");
   AST_BYTE_8BIT: assert property (
      !(low_byte_store_n_o & high_byte_store_n_o) |-> !bus_width_select_i
   ) else $error("byte strobe on 8-bit bus");
   AST_PARITY: assert property (
      low_byte_store_n_o ^ high_byte_store_n_o |->
      ext_addr_o[0] == low_byte_store_n_o) else $error("strobe parity");
   AST_WAIT: assert property (
      (!read_strobe_n_o && !wait_request_n_i) [*3] |=> !read_strobe_n_o
   ) else $error("wait ignored");
endmodule : ebc_ctrl_sva

bind ebc_ctrl ebc_ctrl_sva #(
   .STROBE_CYC_RST(STROBE_CYC_RST)
) u_ebc_ctrl_sva (
   .ref_clk_i(ref_clk_i),
   .rstn_i(rstn_i),
   .bus_width_select_i(bus_width_select_i),
   .bus_request_n_i(bus_request_n_i),
   .wait_request_n_i(wait_request_n_i),
   .ext_data_o(ext_data_o),
   .ext_data_oe_o(ext_data_oe_o),
   .ext_addr_o(ext_addr_o),
   .ext_addr_oe_o(ext_addr_oe_o),
   .chip_select_n_o(chip_select_n_o),
   .ctl_oe_o(ctl_oe_o),
   .addr_latch_pulse_o(addr_latch_pulse_o),
   .low_byte_store_n_o(low_byte_store_n_o),
   .high_byte_store_n_o(high_byte_store_n_o),
   .store_strobe_n_o(store_strobe_n_o),
   .read_strobe_n_o(read_strobe_n_o),
   .bus_grant_n_o(bus_grant_n_o)
);
`default_nettype wire

// file: verif/ebc_mem_model.sv
`default_nettype none
module ebc_mem_model (
   input wire logic clk_i,
   input wire logic rd_n_i,
   input wire logic stb_i,
   input wire logic slow_i,
   input wire logic [15:0] rdat_i,
   output logic [15:0] data_o,
   output logic wait_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] last_r = 16'h0000;
   logic [2:0] cnt_r = 3'h0;
   // Read word only while rd_n_i is low, else a toggling pattern
   assign data_o = !rd_n_i ? rdat_i : ~last_r;
   // Count strobe cycles
   always_ff @(posedge clk_i) begin
      last_r <= data_o;
      cnt_r <= stb_i ? cnt_r + 3'h1 : 3'h0;
   end
   assign wait_n_o = !(slow_i && stb_i && cnt_r < 3'h4);
endmodule : ebc_mem_model
`default_nettype wire

// file: verif/external_memory_bus_ctrl_tb_top.sv
`default_nettype none
module external_memory_bus_ctrl_tb_top
   import ebc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rstn, boot, w8, req_n, slow, clr, pready, e, aoe, coe, ale;
   logic lbs_n, hbs_n, ss_n, ube_n, rd_n, gnt_n, wait_n;
   logic [31:0] prdata, r;
   logic [15:0] din, dout, doe, pdat, rdat, wcap;
   logic [19:0] addr;
   logic [3:0] cs_n;
   logic [23:0] acap;
   logic [4:0] seen;
   ebc_apb_req_t apb;
   int fails, total_checks, seed = 32'h554935f3;
   wire logic stb = !(rd_n & ss_n & lbs_n & hbs_n);
   // Data wire from both drivers
   assign din = (doe & dout) | (~doe & pdat);

   ebc_ctrl u_ebc_ctrl (
      .ref_clk_i(clk), .rstn_i(rstn), .apb_i(apb), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(e), .boot_mode_pin_i(boot),
      .bus_width_select_i(w8), .bus_request_n_i(req_n),
      .wait_request_n_i(wait_n), .ext_data_i(din), .ext_data_o(dout),
      .ext_data_oe_o(doe), .ext_addr_o(addr), .ext_addr_oe_o(aoe),
      .chip_select_n_o(cs_n), .ctl_oe_o(coe), .addr_latch_pulse_o(ale),
      .low_byte_store_n_o(lbs_n), .high_byte_store_n_o(hbs_n),
      .store_strobe_n_o(ss_n), .upper_byte_enable_n_o(ube_n),
      .read_strobe_n_o(rd_n), .bus_grant_n_o(gnt_n));
   ebc_mem_model u_ebc_mem_model (.clk_i(clk), .rd_n_i(rd_n), .stb_i(stb),
      .slow_i(slow), .rdat_i(rdat), .data_o(pdat), .wait_n_o(wait_n));

   ////////////////////////////////////////////////////////////////////////
   // Clock, strobe monitor, watchdog
   always #2 clk = ~clk;
   always @(posedge clk) begin
      seen <= clr ? 5'h0 : seen | ~{lbs_n, hbs_n, ss_n, ube_n, rd_n};
      if (!(ss_n & lbs_n & hbs_n)) wcap <= dout;
      // Select and address seen at the latch pulse
      if (clr) acap <= 24'h0;
      else if (ale) acap <= {cs_n, addr};
   end
   initial begin
      #40000;
      fails++;
      give_verdict();
   end

   ////////////////////////////////////////////////////////////////////////
   // Tasks and expectations
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic apb_xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      apb.penable <= 1'b1;
      // Ends when pready rises; only the watchdog ends it if pready never does
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
   endtask : apb_xfer
   task automatic poll();
      int k;
      k = 0;
      do begin
         apb_xfer(1'b0, EBC_OFS_STATUS, 32'h0, r);
         k++;
      end while (r[0] !== 1'b0 && k < 40);
      check(r[0], 1'b0);
   endtask : poll
   function automatic logic [31:0] exp_st(input logic b, w, sg, rf);
      return {25'h0, 1'b1, rf, sg, w, b, 2'b00};
   endfunction : exp_st
   // Seen strobes: lbs, hbs, single store, ube, read
   function automatic logic [4:0] expv(input logic w, odd, we, sg);
      return {w & !sg & (we | !odd), w & !sg & (we | odd), w & sg,
         sg & (odd | we), !w};
   endfunction : expv
   task automatic access(input logic [1:0] m, input logic w, word);
      logic [19:0] a;
      logic [15:0] d, rv, wv;
      logic odd, we, sg, hi;
      a = 20'($random(seed));
      d = 16'($random(seed));
      rv = 16'($random(seed));
      rdat <= rv;
      slow <= 1'($random(seed));
      sg = m[0] | w8;
      we = word & !w8 & !m[1];
      if (we) a[0] = 1'b0;
      odd = a[0];
      hi = odd & !w8 & !m[1];
      apb_xfer(1'b1, EBC_OFS_CTRL, {24'h0, 4'h3, 2'b00, m[1], m[0]}, r);
      apb_xfer(1'b1, EBC_OFS_ADDR, {12'h0, a}, r);
      apb_xfer(1'b1, EBC_OFS_WDATA, {16'h0, d}, r);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      apb_xfer(1'b1, EBC_OFS_CMD, {29'h0, word, w, 1'b1}, r);
      poll();
      check(seen, expv(w, odd, we, sg));
      check(acap, {~(4'h1 << a[19:18]), a});
      wv = we ? wcap : (hi ? wcap[15:8] : wcap[7:0]);
      if (w) check(wv, we ? d : d[7:0]);
      else begin
         apb_xfer(1'b0, EBC_OFS_RDATA, 32'h0, r);
         check(r, we ? rv : (hi ? rv[15:8] : rv[7:0]));
      end
   endtask : access

   ////////////////////////////////////////////////////////////////////////
   // Main sequence: three strap settings
   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      apb = '0;
      {boot, w8, req_n, slow, clr, rdat} = {5'b10101, 16'h0};
      for (int ph = 0; ph < 3; ph++) begin
         boot <= (ph != 2);
         w8 <= (ph == 1);
         rstn <= 1'b0;
         @(posedge clk);
         #1;
         check({aoe, coe, doe, cs_n, gnt_n, pready}, 24'h00003e);
         @(posedge clk);
         rstn <= 1'b1;
         apb_xfer(1'b0, EBC_OFS_CTRL, 32'h0, r);
         check(r, 32'h30);
         apb_xfer(1'b0, 8'h18, 32'h0, r);
         check({e, r[30:0]}, 32'h80000000);
         apb_xfer(1'b0, EBC_OFS_STATUS, 32'h0, r);
         check(r, exp_st(ph != 2, ph == 1, ph == 1, 1'b0));
         req_n <= 1'b0;
         repeat (6) @(posedge clk);
         check({gnt_n, aoe, coe}, 3'b000);
         apb_xfer(1'b0, EBC_OFS_STATUS, 32'h0, r);
         check(r[1], 1'b1);
         req_n <= 1'b1;
         repeat (5) @(posedge clk);
         check(gnt_n, 1'b1);
         if (ph == 2) begin
            apb_xfer(1'b1, EBC_OFS_CMD, 32'h1, r);
            apb_xfer(1'b0, EBC_OFS_STATUS, 32'h0, r);
            check(r, exp_st(1'b0, 1'b0, 1'b0, 1'b1));
         end else begin
            for (int m = 0; m < 3; m++) begin
               for (int k = 0; k < 4; k++) access(m[1:0], k[0], k[1]);
            end
            apb_xfer(1'b1, EBC_OFS_CMD, 32'h1, r);
            apb_xfer(1'b1, EBC_OFS_CMD, 32'h1, r);
            poll();
            check(r[5], 1'b1);
            apb_xfer(1'b1, EBC_OFS_STATUS, 32'h20, r);
            apb_xfer(1'b0, EBC_OFS_STATUS, 32'h0, r);
            check(r[5], 1'b0);
         end
      end
      give_verdict();
   end
endmodule : external_memory_bus_ctrl_tb_top
`default_nettype wire
